// ---- design/sado_defines.vh ----
// Purpose: Constants for the scan access and output disable block
// Assumes: Included by its bare name
// Notes:   Summary of operation
// Summary of operation
// - Sample mode-select and data-in on each rising test-clock edge.
// - Shift selected register out on data-out, changing only on falling edges.
// - Data-out floats except while a register scan is shifting.
// - Data-out also floats whenever the global output disable is active.
// - Test reset high hands device control to the scan system.
// - Test reset low or open: functional mode, scan inputs ignored.
// - Test reset high: both emulator lines are scan-directed interrupt lines.
// - Test reset low: line a high with line b low floats every device output driver.
// - Host-port ready output floats while output disable is active.
`ifndef SADO_DEFINES_VH
`define SADO_DEFINES_VH
`define SADO_IR_WIDTH      4
`define SADO_IR_CAPTURE    4'h1
`define SADO_IR_EXTEST     4'h0
`define SADO_IR_IDCODE     4'h2
`define SADO_IR_EMUCTRL    4'h8
`define SADO_IR_BYPASS     4'hF
`define SADO_IDCODE        32'h00000001
`define SADO_EMU_WIDTH     4
`define SADO_ST_RESET      4'hF
`define SADO_ST_IDLE       4'hC
`define SADO_ST_SELDR      4'h7
`define SADO_ST_CAPDR      4'h6
`define SADO_ST_SHDR       4'h2
`define SADO_ST_EX1DR      4'h1
`define SADO_ST_PAUSEDR    4'h3
`define SADO_ST_EX2DR      4'h0
`define SADO_ST_UPDDR      4'h5
`define SADO_ST_SELIR      4'h4
`define SADO_ST_CAPIR      4'hE
`define SADO_ST_SHIR       4'hA
`define SADO_ST_EX1IR      4'h9
`define SADO_ST_PAUSEIR    4'hB
`define SADO_ST_EX2IR      4'h8
`define SADO_ST_UPDIR      4'hD
`endif

// ---- design/sado_sync.v ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level inputs, mclk domain
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module sado_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             mclk,
   input  wire             reset,
   // Data
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   // First stage is read only by the second
   always @(posedge mclk) begin
      if (reset) begin
         stage1  <= {WIDTH{1'b0}};
         stage2  <= {WIDTH{1'b0}};
         stage3  <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         stage1 <= asyncIn;
         stage2 <= stage1;
         stage3 <= stage2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2[i] == stage3[i]) begin
               syncOut[i] <= stage3[i];
            end
         end
      end
   end
endmodule

// ---- design/sado_scan_access.v ----
// Purpose: Scan access port, emulator lines and global output disable
// Assumes: Test clock far slower than mclk, sampled as a plain input
// Notes:   Test logic advances on detected test-clock edges only
`timescale 1ns/1ps
`include "sado_defines.vh"
module sado_scan_access #(
   parameter IR_WIDTH  = `SADO_IR_WIDTH,
   parameter EMU_WIDTH = `SADO_EMU_WIDTH
) (
   // Clock and reset
   input  wire mclk,
   input  wire reset,
   // Scan port pins
   input  wire testClock,
   input  wire testModeSelect,
   input  wire testDataIn,
   input  wire testReset,
   output reg  testDataOut,
   output reg  testDataOutEn,
   // Emulator lines, three signals each
   input  wire emulator_event_line_a_in,
   output reg  emulator_event_line_a_out,
   output reg  emulator_event_line_a_oe,
   input  wire emulator_line_b_output_disable_in,
   output reg  emulator_line_b_output_disable_out,
   output reg  emulator_line_b_output_disable_oe,
   // Device side
   input  wire hostReadyIn,
   input  wire hostInterruptIn,
   input  wire emuEventAIn,
   input  wire emuEventBIn,
   output reg  host_port_ready_out,
   output reg  host_port_ready_out_oe,
   output reg  host_interrupt_out,
   output reg  host_interrupt_out_oe,
   output reg  emuEventAOut,
   output reg  emuEventBOut,
   output reg  scanControl,
   output reg  outputsEnabled
);
   wire [5:0] syncPins;
   reg        tckPrev;
   reg  [3:0] tapState;
   reg  [3:0] next_tapState;
   reg  [IR_WIDTH-1:0]  instr;
   reg  [IR_WIDTH-1:0]  irShift;
   reg  [31:0]          drShift;
   reg  [EMU_WIDTH-1:0] emuCtrl;
   reg                  tdoBit;
   reg                  shiftActive;

   wire tck       = syncPins[0];
   wire tms       = syncPins[1];
   wire tdi       = syncPins[2];
   wire trst      = syncPins[3];
   wire lineA     = syncPins[4];
   wire lineB     = syncPins[5];
   wire tckRise   = tck & ~tckPrev;
   wire tckFall   = ~tck & tckPrev;
   // Test reset low ignores the scan port entirely
   wire scanOn    = trst;
   wire disableOn = ~trst & lineA & ~lineB;

   // Pins from outside the mclk domain
   sado_sync #(.WIDTH(6)) uSync (
      .mclk    (mclk),
      .reset   (reset),
      .asyncIn ({emulator_line_b_output_disable_in, emulator_event_line_a_in,
                 testReset, testDataIn, testModeSelect, testClock}),
      .syncOut (syncPins)
   );

   // Length of the data register picked by the instruction
   function [5:0] drLength;
      input [IR_WIDTH-1:0] ir;
      begin
         case (ir)
            `SADO_IR_IDCODE:  drLength = 6'd32;
            `SADO_IR_EMUCTRL: drLength = 6'd4;
            default:          drLength = 6'd1;
         endcase
      end
   endfunction

   // Standard sixteen-state sequence
   always @* begin
      case (tapState)
         `SADO_ST_RESET:   next_tapState = tms ? `SADO_ST_RESET : `SADO_ST_IDLE;
         `SADO_ST_IDLE:    next_tapState = tms ? `SADO_ST_SELDR : `SADO_ST_IDLE;
         `SADO_ST_SELDR:   next_tapState = tms ? `SADO_ST_SELIR : `SADO_ST_CAPDR;
         `SADO_ST_CAPDR:   next_tapState = tms ? `SADO_ST_EX1DR : `SADO_ST_SHDR;
         `SADO_ST_SHDR:    next_tapState = tms ? `SADO_ST_EX1DR : `SADO_ST_SHDR;
         `SADO_ST_EX1DR:   next_tapState = tms ? `SADO_ST_UPDDR : `SADO_ST_PAUSEDR;
         `SADO_ST_PAUSEDR: next_tapState = tms ? `SADO_ST_EX2DR : `SADO_ST_PAUSEDR;
         `SADO_ST_EX2DR:   next_tapState = tms ? `SADO_ST_UPDDR : `SADO_ST_SHDR;
         `SADO_ST_UPDDR:   next_tapState = tms ? `SADO_ST_SELDR : `SADO_ST_IDLE;
         `SADO_ST_SELIR:   next_tapState = tms ? `SADO_ST_RESET : `SADO_ST_CAPIR;
         `SADO_ST_CAPIR:   next_tapState = tms ? `SADO_ST_EX1IR : `SADO_ST_SHIR;
         `SADO_ST_SHIR:    next_tapState = tms ? `SADO_ST_EX1IR : `SADO_ST_SHIR;
         `SADO_ST_EX1IR:   next_tapState = tms ? `SADO_ST_UPDIR : `SADO_ST_PAUSEIR;
         `SADO_ST_PAUSEIR: next_tapState = tms ? `SADO_ST_EX2IR : `SADO_ST_PAUSEIR;
         `SADO_ST_EX2IR:   next_tapState = tms ? `SADO_ST_UPDIR : `SADO_ST_SHIR;
         `SADO_ST_UPDIR:   next_tapState = tms ? `SADO_ST_SELDR : `SADO_ST_IDLE;
         default:          next_tapState = `SADO_ST_RESET;
      endcase
   end

   // Rising edge work: state, capture and shift-in
   always @(posedge mclk) begin
      if (reset) begin
         tckPrev  <= 1'b0;
         tapState <= `SADO_ST_RESET;
         instr    <= `SADO_IR_IDCODE;
         irShift  <= {IR_WIDTH{1'b0}};
         drShift  <= 32'h00000000;
         emuCtrl  <= {EMU_WIDTH{1'b0}};
      end else begin
         tckPrev <= tck;
         if (!scanOn) begin
            // Held in reset while functional, so scan pins have no effect
            tapState <= `SADO_ST_RESET;
            instr    <= `SADO_IR_IDCODE;
            emuCtrl  <= {EMU_WIDTH{1'b0}};
         end else if (tckRise) begin
            tapState <= next_tapState;
            case (tapState)
               `SADO_ST_RESET: instr <= `SADO_IR_IDCODE;
               `SADO_ST_CAPIR: irShift <= `SADO_IR_CAPTURE;
               `SADO_ST_SHIR:  irShift <= {tdi, irShift[IR_WIDTH-1:1]};
               `SADO_ST_UPDIR: instr <= irShift;
               `SADO_ST_CAPDR: begin
                  if (instr == `SADO_IR_IDCODE) begin
                     drShift <= `SADO_IDCODE;
                  end else if (instr == `SADO_IR_EMUCTRL) begin
                     drShift <= {28'h0000000, lineB, lineA, emuCtrl[1:0]};
                  end else begin
                     drShift <= 32'h00000000;
                  end
               end
               `SADO_ST_SHDR: begin
                  // Insert at the top of the selected length
                  drShift <= (drShift >> 1) |
                             ({31'h00000000, tdi} << (drLength(instr) - 6'd1));
               end
               `SADO_ST_UPDDR: begin
                  if (instr == `SADO_IR_EMUCTRL) begin
                     emuCtrl <= drShift[EMU_WIDTH-1:0];
                  end
               end
               default: begin
                  instr <= instr;
               end
            endcase
         end
      end
   end

   // Falling edge work: data-out changes here only
   always @(posedge mclk) begin
      if (reset) begin
         tdoBit      <= 1'b0;
         shiftActive <= 1'b0;
      end else if (!scanOn) begin
         shiftActive <= 1'b0;
      end else if (tckFall) begin
         shiftActive <= (tapState == `SADO_ST_SHDR) || (tapState == `SADO_ST_SHIR);
         tdoBit      <= (tapState == `SADO_ST_SHIR) ? irShift[0] : drShift[0];
      end
   end

   // Registered pin drivers and device-side controls
   always @(posedge mclk) begin
      if (reset) begin
         testDataOut                        <= 1'b0;
         testDataOutEn                      <= 1'b0;
         emulator_event_line_a_out          <= 1'b0;
         emulator_event_line_a_oe           <= 1'b0;
         emulator_line_b_output_disable_out <= 1'b0;
         emulator_line_b_output_disable_oe  <= 1'b0;
         host_port_ready_out                <= 1'b0;
         host_port_ready_out_oe             <= 1'b0;
         host_interrupt_out                 <= 1'b0;
         host_interrupt_out_oe              <= 1'b0;
         emuEventAOut                       <= 1'b0;
         emuEventBOut                       <= 1'b0;
         scanControl                        <= 1'b0;
         outputsEnabled                     <= 1'b1;
      end else begin
         testDataOut    <= tdoBit;
         testDataOutEn  <= shiftActive & ~disableOn;
         scanControl    <= scanOn;
         outputsEnabled <= ~disableOn;
         // Emulator lines: direction from scan control bits 2 and 3
         emulator_event_line_a_out          <= emuCtrl[0] | emuEventAIn;
         emulator_event_line_a_oe           <= scanOn & emuCtrl[2];
         emulator_line_b_output_disable_out <= emuCtrl[1] | emuEventBIn;
         emulator_line_b_output_disable_oe  <= scanOn & emuCtrl[3];
         emuEventAOut   <= scanOn & ~emuCtrl[2] & lineA;
         emuEventBOut   <= scanOn & ~emuCtrl[3] & lineB;
         host_port_ready_out    <= hostReadyIn;
         host_port_ready_out_oe <= ~disableOn;
         host_interrupt_out     <= hostInterruptIn;
         host_interrupt_out_oe  <= ~disableOn;
      end
   end
endmodule

// ---- verification/sado_properties.sv ----
// Purpose: Pin-level checks for the scan access block
// Assumes: Pins sampled on mclk, test clock far slower than mclk
// Notes:   Windows of 8 mclk cover the synchroniser latency
`timescale 1ns/1ps
module sado_properties (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Scan and emulator pins
   input wire testClock,
   input wire testReset,
   input wire testDataOut,
   input wire testDataOutEn,
   input wire emulator_event_line_a_in,
   input wire emulator_line_b_output_disable_in,
   // Device side
   input wire host_port_ready_out_oe,
   input wire host_interrupt_out_oe,
   input wire scanControl,
   input wire outputsEnabled
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Mode follows the test reset pin once it settles
   property p_func; (!testReset)[*8] |=> !scanControl && !testDataOutEn; endproperty
   a_func: assert property (p_func) else $error("scan active in functional mode");
   property p_scan; testReset[*8] |=> scanControl; endproperty
   a_scan: assert property (p_scan) else $error("scan control not taken");
   // Global disable floats data-out and both host drivers
   property p_tdo_off; !outputsEnabled |-> !testDataOutEn; endproperty
   a_tdo_off: assert property (p_tdo_off) else $error("data-out driven while disabled");
   property p_host_off; !outputsEnabled |-> !host_port_ready_out_oe && !host_interrupt_out_oe;
   endproperty
   a_host_off: assert property (p_host_off) else $error("host pin driven");
   // Disable follows exactly its three pin conditions
   property p_dis; (!testReset && emulator_event_line_a_in
      && !emulator_line_b_output_disable_in)[*8] |=> !outputsEnabled; endproperty
   a_dis: assert property (p_dis) else $error("disable not applied");
   property p_en; (testReset || !emulator_event_line_a_in
      || emulator_line_b_output_disable_in)[*8] |=> outputsEnabled; endproperty
   a_en: assert property (p_en) else $error("outputs disabled without cause");
   // Data-out moves only after a test-clock fall; pin seen 4 mclk back, the sync latency
   property p_fall; $changed(testDataOut) && testDataOutEn |-> !$past(testClock, 4);
   endproperty
   a_fall: assert property (p_fall) else $error("data-out changed off the fall");
   property p_en_fall; $rose(testDataOutEn) |-> !$past(testClock, 4); endproperty
   a_en_fall: assert property (p_en_fall) else $error("data-out enabled off phase");
   c_dis: cover property (!outputsEnabled);
   c_tdo: cover property ($rose(testDataOutEn));
   c_scan: cover property ($rose(scanControl));
endmodule

// ---- verification/sado_tester.sv ----
// Purpose: Scan tester model driving the test port
// Assumes: Calls start on a falling mclk edge
// Notes:   Test clock stands still between calls
`timescale 1ns/1ps
module sado_tester (
   // Clock
   input  wire mclk,
   // Data-out pin
   input  wire testDataOut,
   input  wire testDataOutEn,
   // Scan pins
   output reg  testClock,
   output reg  testModeSelect,
   output reg  testDataIn
);
   reg lastTdo;
   // Idle levels, pull-ups on select and data-in
   initial begin
      testClock = 1'b0;
      testModeSelect = 1'b1;
      testDataIn = 1'b1;
      lastTdo = 1'b0;
   end
   // One 400 ns period, equal halves
   task step(input m, input d, output q);
      begin
         testModeSelect = m; // Changes only while the clock is low
         testDataIn = d;
         repeat (4) @(negedge mclk);
         testClock = 1'b1;
         repeat (4) @(negedge mclk);
         // A floated pin reads back inverted, not as a held value
         q = testDataOutEn ? testDataOut : ~lastTdo;
         lastTdo = q;
         testClock = 1'b0;
      end
   endtask
endmodule

// ---- verification/test_scan_access_and_output_disable.sv ----
// Purpose: Self-checking bench for the scan access block
// Assumes: Tester model makes the 400 ns test clock
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
`include "sado_defines.vh"
module test_scan_access_and_output_disable;
   reg         mclk, reset, testReset, aDrv, bDrv, e, x;
   reg         hostReadyIn, hostInterruptIn, emuEventAIn, emuEventBIn;
   integer     seed, n_fail, comparisons, k;
   reg  [31:0] d, q;
   wire        testClock, testModeSelect, testDataIn, testDataOut, testDataOutEn;
   wire        aOut, aOe, bOut, bOe, hro, hroe, hio, hioe, eAo, eBo, scanControl, outputsEnabled;
   // Line level from whoever drives it
   wire        lineA = aOe ? aOut : aDrv;
   wire        lineB = bOe ? bOut : bDrv;
   sado_scan_access u_dut (.mclk(mclk), .reset(reset), .testClock(testClock),
      .testModeSelect(testModeSelect), .testDataIn(testDataIn), .testReset(testReset),
      .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
      .emulator_event_line_a_in(lineA), .emulator_event_line_a_out(aOut),
      .emulator_event_line_a_oe(aOe), .emulator_line_b_output_disable_in(lineB),
      .emulator_line_b_output_disable_out(bOut), .emulator_line_b_output_disable_oe(bOe),
      .hostReadyIn(hostReadyIn), .hostInterruptIn(hostInterruptIn), .emuEventAIn(emuEventAIn),
      .emuEventBIn(emuEventBIn), .host_port_ready_out(hro), .host_port_ready_out_oe(hroe),
      .host_interrupt_out(hio), .host_interrupt_out_oe(hioe), .emuEventAOut(eAo),
      .emuEventBOut(eBo), .scanControl(scanControl), .outputsEnabled(outputsEnabled));
   sado_tester u_tester (.mclk(mclk), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
      .testClock(testClock), .testModeSelect(testModeSelect), .testDataIn(testDataIn));
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wt(input integer n);
      repeat (n) @(negedge mclk);
   endtask
   // Idle to Idle through one scan of n bits, LSB first
   task scan(input ir, input integer n, input [31:0] din);
      integer i;
      begin
         u_tester.step(1'b1, 1'b1, x);
         if (ir) u_tester.step(1'b1, 1'b1, x);
         u_tester.step(1'b0, 1'b1, x);
         u_tester.step(1'b0, 1'b1, x);
         q = 32'h0;
         for (i = 0; i < n; i = i + 1) u_tester.step(i == n - 1, din[i], q[i]);
         u_tester.step(1'b1, 1'b1, x);
         u_tester.step(1'b0, 1'b1, x);
      end
   endtask
   // One-bit bypass stage delays data by one bit
   function [31:0] byp(input [31:0] din, input integer n);
      byp = {din[30:0], 1'b0} & ((32'h1 << n) - 1);
   endfunction
   task results;
      begin
         $display("comparisons %0d n_fail %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Whole run is near 110 test-clock periods; allow over ten times that
   initial begin
      #2000000;
      n_fail = n_fail + 1;
      results;
   end
   initial begin
      seed = 53505;
      n_fail = 0;
      comparisons = 0;
      {reset, testReset, aDrv, bDrv} = 4'h9;
      {hostReadyIn, hostInterruptIn, emuEventAIn, emuEventBIn} = $random(seed);
      wt(10);
      reset = 1'b0;
      wt(8);
      chk("enabled", 1, outputsEnabled);
      chk("tdoEn", 0, testDataOutEn);
      $display("test reset done");
      // Every line combination, disable only as a test pattern
      for (k = 0; k < 5; k = k + 1) begin
         {testReset, aDrv, bDrv} = {k[2], k[0] | k[2], k[1] & ~k[2]};
         {hostReadyIn, hostInterruptIn} = $random(seed);
         e = ~(aDrv & ~bDrv & ~testReset);
         wt(10);
         chk("enabled", e, outputsEnabled);
         chk("readyOe", e, hroe);
         chk("intOe", e, hioe);
         chk("ready", hostReadyIn, hro);
         chk("interrupt", hostInterruptIn, hio);
      end
      $display("test disable done");
      {testReset, aDrv, bDrv} = 3'h1;
      wt(10);
      scan(1'b1, 4, `SADO_IR_BYPASS);
      chk("scanCtl", 0, scanControl);
      testReset = 1'b1;
      wt(10);
      chk("scanCtl", 1, scanControl);
      u_tester.step(1'b0, 1'b1, x);
      scan(1'b0, 32, $random(seed));
      chk("idcode", `SADO_IDCODE, q);
      scan(1'b1, 4, `SADO_IR_BYPASS);
      chk("irCapture", `SADO_IR_CAPTURE, q);
      d = $random(seed);
      scan(1'b0, 16, d);
      chk("bypass", byp(d, 16), q);
      $display("test scan done");
      scan(1'b1, 4, `SADO_IR_EMUCTRL);
      scan(1'b0, 4, 32'h4);
      bDrv = $random(seed);
      wt(10);
      chk("lineAOe", 1, aOe);
      chk("lineBOe", 0, bOe);
      chk("lineBIn", bDrv, eBo);
      chk("lineAIn", 0, eAo);
      chk("lineAOut", emuEventAIn, aOut);
      chk("lineBOut", emuEventBIn, bOut);
      {testReset, aDrv, bDrv} = 3'h2;
      wt(12);
      chk("lineAOe", 0, aOe);
      chk("enabled", 0, outputsEnabled);
      $display("test emulator done");
      results;
   end
endmodule
bind sado_scan_access sado_properties u_props (.*);
